// file: core/uartdi_regs.sv
// Data and interrupt registers of the UART, with a framing transmitter.
// Assumes the host strobes, line format and event pulses are synchronous.
`default_nettype none

module uartdi_regs #(
  parameter int DATA_W = 8,
  parameter int DEPTH  = uartdi_pkg::TXBUF_DEPTH
) (
  input  wire logic                    mclk_i,
  input  wire logic                    reset_i,
  input  wire uartdi_pkg::uartdi_host_t host_i,
  input  wire logic                    port_mode_select_i,
  input  wire uartdi_pkg::uartdi_fmt_t fmt_i,
  input  wire logic                    rx_valid_i,
  input  wire logic [7:0]              rx_data_i,
  output logic                         rx_ready_o,
  input  wire logic                    line_err_i,
  input  wire logic                    modem_change_i,
  input  wire logic                    sample_tick_i,
  output logic                         tx_serial_o,
  output logic                         tx_ready_o,
  output logic [7:0]                   host_rdata_o,
  output logic                         host_rdata_oe_o,
  output logic                         interrupt_output_o
);
  import uartdi_pkg::*;

  if (DATA_W != 8) begin : g_chk_w
    $error("DATA_W must be 8");
  end
  if (DEPTH != 2) begin : g_chk_d
    $error("DEPTH must be 2");
  end

  function automatic logic hit(input logic [3:0] a,
                               input logic       mode,
                               input logic [3:0] off);
    hit = mode ? (a == off)
               : (a[2:0] == off[2:0]);
  endfunction

  function automatic logic [7:0] len_mask(input logic [1:0] wl);
    case (wl)
      2'h0:    len_mask = 8'h1F;
      2'h1:    len_mask = 8'h3F;
      2'h2:    len_mask = 8'h7F;
      default: len_mask = 8'hFF;
    endcase
  endfunction

  function automatic logic [2:0] prio(input logic [3:0] en);
    if (en[IEN_LS])        prio = IID_LS;
    else if (en[IEN_RDA])  prio = IID_RDA;
    else if (en[IEN_THRE]) prio = IID_THRE;
    else if (en[IEN_MS])   prio = IID_MS;
    else                   prio = IID_NONE;
  endfunction

  function automatic logic active(input logic [2:0] id,
                                  input logic [3:0] en);
    case (id)
      IID_LS:   active = en[IEN_LS];
      IID_RDA:  active = en[IEN_RDA];
      IID_THRE: active = en[IEN_THRE];
      IID_MS:   active = en[IEN_MS];
      default:  active = 1'b0;
    endcase
  endfunction

  // Host strobe edges
  logic rd_q;
  logic wr_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      rd_q <= host_i.host_read_strobe;
      wr_q <= host_i.host_write_strobe;
    end
  end

  logic       rd_rise;
  logic       wr_rise;
  logic       div_sel;
  logic       sel_data;
  logic       sel_ien;
  logic       sel_iid;
  logic       rd_rxbuf;
  logic       wr_hold;
  logic       wr_ien;
  logic       rd_iid;
  logic       rd_lstat;
  logic       rd_mstat;
  logic [3:0] ha;

  assign ha       = host_i.host_address_lines;
  assign rd_rise  = host_i.host_read_strobe & ~rd_q;
  assign wr_rise  = host_i.host_write_strobe & ~wr_q;
  assign div_sel  = fmt_i.divisor_access_select;
  // Divisor latches shadow offsets 0 and 1 while div_sel is set
  assign sel_data = hit(ha, port_mode_select_i, ADDR_DATA) & ~div_sel;
  assign sel_ien  = hit(ha, port_mode_select_i, ADDR_IEN) & ~div_sel;
  assign sel_iid  = hit(ha, port_mode_select_i, ADDR_IID);
  assign rd_rxbuf = rd_rise & sel_data;
  assign wr_hold  = wr_rise & sel_data;
  assign wr_ien   = wr_rise & sel_ien;
  assign rd_iid   = rd_rise & sel_iid;
  assign rd_lstat = rd_rise & hit(ha, port_mode_select_i, ADDR_LSTAT);
  assign rd_mstat = rd_rise & hit(ha, port_mode_select_i, ADDR_MSTAT);

  // Interrupt enable register
  logic [7:0] ien_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ien_q <= IEN_RESET;
    end else if (wr_ien) begin
      ien_q <= host_i.wdata & IEN_MASK;
    end
  end

  // Receive buffer
  logic [7:0] rxbuf_q;
  logic       rxbuf_full_q;
  logic       rxbuf_full_d;
  logic       rx_take;
  assign rx_take = rx_valid_i & rx_ready_o;
  always_comb begin
    rxbuf_full_d = rxbuf_full_q;
    if (rx_take) begin
      rxbuf_full_d = 1'b1;
    end else if (rd_rxbuf) begin
      rxbuf_full_d = 1'b0;
    end
  end
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rxbuf_q      <= 8'h00;
      rxbuf_full_q <= 1'b0;
      rx_ready_o   <= 1'b0;
    end else begin
      if (rx_take) begin
        rxbuf_q <= rx_data_i;
      end
      rxbuf_full_q <= rxbuf_full_d;
      rx_ready_o   <= ~rxbuf_full_d;
    end
  end

  // Two-entry transmit buffer; a write while full is dropped
  logic [7:0] buf_q [DEPTH];
  logic       wp_q;
  logic       rp_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       push;
  logic       pop;
  uartdi_tx_t st_q;
  assign push = wr_hold & (cnt_q != 2'h2);
  assign pop  = (st_q == TX_IDLE) & (cnt_q != 2'h0);
  always_comb begin
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      wp_q       <= 1'b0;
      rp_q       <= 1'b0;
      cnt_q      <= 2'h0;
      tx_ready_o <= 1'b1;
      buf_q[0]   <= 8'h00;
      buf_q[1]   <= 8'h00;
    end else begin
      if (push) begin
        buf_q[wp_q] <= host_i.wdata;
        wp_q        <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q      <= cnt_d;
      tx_ready_o <= (cnt_d != 2'h2);
    end
  end

  // Framing transmitter, timed in sample ticks
  uartdi_fmt_t tf_q;
  logic [7:0]  sh_q;
  logic [2:0]  bit_q;
  logic [5:0]  tk_q;
  logic [5:0]  lim;
  logic        bit_end;
  always_comb begin
    lim = 6'(OVERSAMPLE);
    if (st_q == TX_STOP && tf_q.stop2) begin
      // Five-bit words get one and a half stop bits
      lim = (tf_q.word_len == 2'h0) ? 6'(OVERSAMPLE * 3 / 2)
                                    : 6'(OVERSAMPLE * 2);
    end
  end
  assign bit_end = sample_tick_i & (tk_q == lim - 6'h1);

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q  <= TX_IDLE;
      tf_q  <= '0;
      sh_q  <= 8'h00;
      bit_q <= 3'h0;
      tk_q  <= 6'h00;
    end else begin
      if (st_q == TX_IDLE) begin
        tk_q <= 6'h00;
      end else if (bit_end) begin
        tk_q <= 6'h00;
      end else if (sample_tick_i) begin
        tk_q <= tk_q + 6'h1;
      end
      case (st_q)
        TX_IDLE: begin
          if (pop) begin
            // Format latched so a mid-frame change cannot tear it
            tf_q <= fmt_i;
            sh_q <= buf_q[rp_q] & len_mask(fmt_i.word_len);
            st_q <= TX_START;
          end
        end
        TX_START: begin
          if (bit_end) begin
            bit_q <= 3'h0;
            st_q  <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (bit_end) begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'(4 + tf_q.word_len)) begin
              st_q <= tf_q.par_en ? TX_PARITY : TX_STOP;
            end
          end
        end
        TX_PARITY: begin
          if (bit_end) begin
            st_q <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (bit_end) begin
            st_q <= TX_IDLE;
          end
        end
        default: st_q <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_serial_o <= 1'b1;
    end else begin
      case (st_q)
        TX_START:  tx_serial_o <= 1'b0;
        TX_DATA:   tx_serial_o <= sh_q[bit_q];
        TX_PARITY: tx_serial_o <= tf_q.par_even ? ^sh_q : ~^sh_q;
        default:   tx_serial_o <= 1'b1;
      endcase
    end
  end

  // Interrupt sources and identification
  logic       ls_pend_q;
  logic       ms_pend_q;
  logic       thre_pend_q;
  logic [3:0] pend;
  logic [3:0] en;
  logic       frz_q;
  logic [2:0] frz_id_q;
  logic [2:0] id_live;
  logic [2:0] id_cur;
  logic       thre_set;
  logic       thre_clr;

  assign pend = {ms_pend_q, ls_pend_q, thre_pend_q, rxbuf_full_q};
  assign en   = pend & ien_q[3:0];
  assign id_live = prio(en);
  assign id_cur  = frz_q ? frz_id_q : id_live;
  assign thre_set = (cnt_q != 2'h0) & (cnt_d == 2'h0);
  assign thre_clr = wr_hold | (rd_iid & (id_cur == IID_THRE));

  // Event wins over a clear in the same cycle
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ls_pend_q   <= 1'b0;
      ms_pend_q   <= 1'b0;
      thre_pend_q <= 1'b0;
    end else begin
      ls_pend_q   <= line_err_i | (ls_pend_q & ~rd_lstat);
      ms_pend_q   <= modem_change_i | (ms_pend_q & ~rd_mstat);
      thre_pend_q <= thre_set | (thre_pend_q & ~thre_clr);
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      frz_q    <= 1'b0;
      frz_id_q <= IID_NONE;
    end else if (frz_q) begin
      if (!active(frz_id_q, en)) begin
        frz_q <= 1'b0;
      end
    end else if (rd_iid && id_live != IID_NONE
                 && id_live != IID_THRE) begin
      // Holding empty is cleared by this very read, so never frozen
      frz_q    <= 1'b1;
      frz_id_q <= id_live;
    end
  end

  logic intr_d;
  always_comb begin
    intr_d = frz_q ? active(frz_id_q, en) : (en != 4'h0);
    if (ien_q[IEN_COMPAT] && host_i.host_read_strobe) begin
      intr_d = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      interrupt_output_o <= 1'b0;
    end else begin
      interrupt_output_o <= intr_d;
    end
  end

  // Read data is captured on the strobe edge and held for its length
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      host_rdata_o    <= 8'h00;
      host_rdata_oe_o <= 1'b0;
    end else begin
      host_rdata_oe_o <= host_i.host_read_strobe
                         & (sel_data | sel_ien | sel_iid);
      if (rd_rise) begin
        if (sel_data) begin
          host_rdata_o <= rxbuf_q & len_mask(fmt_i.word_len);
        end else if (sel_ien) begin
          host_rdata_o <= ien_q & IEN_MASK;
        end else if (sel_iid) begin
          host_rdata_o <= {5'h00, id_cur};
        end
      end
    end
  end

  property p_rxbuf_mask;
    @(posedge mclk_i) disable iff (reset_i)
    rd_rxbuf |=> (host_rdata_o & ~len_mask($past(fmt_i.word_len))) == 8'h00;
  endproperty
  a_rxbuf_mask: assert property (p_rxbuf_mask)
    else $error("receive data upper bits not zero");

  property p_start_bit;
    @(posedge mclk_i) disable iff (reset_i)
    $rose(st_q == TX_START) |=> !tx_serial_o;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("start bit not low");

  property p_ien_write;
    @(posedge mclk_i) disable iff (reset_i)
    wr_ien |=> ien_q == ($past(host_i.wdata) & IEN_MASK);
  endproperty
  a_ien_write: assert property (p_ien_write)
    else $error("enable register not written");

  property p_no_enable;
    @(posedge mclk_i) disable iff (reset_i)
    (ien_q[3:0] == 4'h0) |=> !interrupt_output_o;
  endproperty
  a_no_enable: assert property (p_no_enable)
    else $error("interrupt with all enables clear");

  property p_ien_high;
    @(posedge mclk_i) disable iff (reset_i)
    (rd_rise & sel_ien) |=> host_rdata_o[7:5] == 3'h0;
  endproperty
  a_ien_high: assert property (p_ien_high)
    else $error("enable upper bits not zero");

  property p_freeze;
    @(posedge mclk_i) disable iff (reset_i)
    (frz_q & rd_iid) |=> host_rdata_o[2:0] == $past(frz_id_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("frozen source not reported");

  property p_iid_read;
    @(posedge mclk_i) disable iff (reset_i)
    rd_iid |=> host_rdata_o[7:3] == 5'h00
      && host_rdata_o[0] == ($past(id_cur) == IID_NONE);
  endproperty
  a_iid_read: assert property (p_iid_read)
    else $error("identification pending bit wrong");

  property p_ls_top;
    @(posedge mclk_i) disable iff (reset_i)
    (rd_iid & ~frz_q & en[IEN_LS]) |=> host_rdata_o[2:0] == IID_LS;
  endproperty
  a_ls_top: assert property (p_ls_top)
    else $error("line status not top priority");

  property p_ls_clr;
    @(posedge mclk_i) disable iff (reset_i)
    (rd_lstat & ~line_err_i) |=> !ls_pend_q;
  endproperty
  a_ls_clr: assert property (p_ls_clr)
    else $error("line status source not cleared");

  property p_thre_clr;
    @(posedge mclk_i) disable iff (reset_i)
    wr_hold |=> !thre_pend_q;
  endproperty
  a_thre_clr: assert property (p_thre_clr)
    else $error("holding empty not cleared by write");

  property p_intr_drop;
    @(posedge mclk_i) disable iff (reset_i)
    (en == 4'h0) |=> !interrupt_output_o;
  endproperty
  a_intr_drop: assert property (p_intr_drop)
    else $error("interrupt held with nothing pending");

endmodule : uartdi_regs

`default_nettype wire

// file: core/uartdi_pkg.sv
// Constants and carrier types for the UART data and interrupt registers.
// Assumes a synchronous host bus sampled on mclk_i.
`default_nettype none

package uartdi_pkg;

  localparam logic [3:0] ADDR_DATA  = 4'h0;
  localparam logic [3:0] ADDR_IEN   = 4'h1;
  localparam logic [3:0] ADDR_IID   = 4'h2;
  localparam logic [3:0] ADDR_LSTAT = 4'h5;
  localparam logic [3:0] ADDR_MSTAT = 4'h6;

  localparam int IEN_RDA    = 0;
  localparam int IEN_THRE   = 1;
  localparam int IEN_LS     = 2;
  localparam int IEN_MS     = 3;
  localparam int IEN_COMPAT = 4;
  localparam logic [7:0] IEN_RESET = 8'h00;
  localparam logic [7:0] IEN_MASK  = 8'h1F;

  localparam logic [2:0] IID_NONE = 3'h1;
  localparam logic [2:0] IID_LS   = 3'h6;
  localparam logic [2:0] IID_RDA  = 3'h4;
  localparam logic [2:0] IID_THRE = 3'h2;
  localparam logic [2:0] IID_MS   = 3'h0;

  localparam int OVERSAMPLE = 16;
  localparam int TXBUF_DEPTH = 2;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP
  } uartdi_tx_t;

  typedef struct packed {
    logic       host_read_strobe;
    logic       host_write_strobe;
    logic [3:0] host_address_lines;
    logic [7:0] wdata;
  } uartdi_host_t;

  typedef struct packed {
    logic [1:0] word_len;
    logic       stop2;
    logic       par_en;
    logic       par_even;
    logic       divisor_access_select;
  } uartdi_fmt_t;

endpackage : uartdi_pkg

`default_nettype wire

// file: tb/uartdi_far_model.sv
// Far side model: sample ticks, receive character source, serial capture.
// Assumes captured frames carry 8 data bits and no parity.
`default_nettype none

module uartdi_far_model (
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       send_i,
  input  wire logic [7:0] send_data_i,
  input  wire logic       rx_ready_i,
  input  wire logic       tx_serial_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            sample_tick_o,
  output logic            got_o,
  output logic [7:0]      got_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_q;
  logic       busy_q;
  logic [7:0] cnt_q;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      div_q         <= 2'h0;
      sample_tick_o <= 1'b0;
      rx_valid_o    <= 1'b0;
      rx_data_o     <= 8'h00;
    end else begin
      div_q         <= div_q + 2'h1;
      sample_tick_o <= (div_q == 2'h3);
      // Released data shows the inverse, never a stale copy
      if (send_i) begin
        rx_valid_o <= 1'b1;
        rx_data_o  <= send_data_i;
      end else if (rx_valid_o && rx_ready_i) begin
        rx_valid_o <= 1'b0;
        rx_data_o  <= ~rx_data_o;
      end
    end
  end

  // Mid-bit sampling, sixteen ticks a bit
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_q     <= 1'b0;
      cnt_q      <= 8'h00;
      got_o      <= 1'b0;
      got_data_o <= 8'h00;
    end else begin
      got_o <= 1'b0;
      if (sample_tick_o && !busy_q && !tx_serial_i) begin
        busy_q <= 1'b1;
        cnt_q  <= 8'h01;
      end else if (sample_tick_o && busy_q) begin
        cnt_q <= cnt_q + 8'h01;
        if (cnt_q == 8'h98) begin
          busy_q <= 1'b0;
          got_o  <= tx_serial_i;
        end else if (cnt_q[3:0] == 4'h8 && cnt_q[7:4] != 4'h0) begin
          got_data_o <= {tx_serial_i, got_data_o[7:1]};
        end
      end
    end
  end
endmodule // uartdi_far_model

`default_nettype wire

// file: tb/uartdi_regs_bench.sv
// Bench for the UART data and interrupt registers.
// Assumes the far model makes ticks and serves both streams.
`default_nettype none

module uartdi_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import uartdi_pkg::*;
  logic         mclk  = 1'b0;
  logic         rst   = 1'b1;
  uartdi_host_t host  = '0;
  logic         pmode = 1'b1;
  uartdi_fmt_t  fmt   = '0;
  logic         lerr  = 1'b0;
  logic         mchg  = 1'b0;
  logic         send  = 1'b0;
  logic [7:0]   sdata = 8'h00;
  logic [7:0]   rd_v;
  logic         oe_v;
  logic         rx_valid, rx_ready, tick, txs, txr, oe, intr, got;
  logic [7:0]   rx_data, rdata, got_data;
  logic [7:0]   got_q[$];
  int           n_mismatch  = 0;
  int           check_count = 0;

  always #25 mclk = ~mclk;

  uartdi_regs uartdi_regs_i (.mclk_i(mclk), .reset_i(rst), .host_i(host),
    .port_mode_select_i(pmode), .fmt_i(fmt), .rx_valid_i(rx_valid),
    .rx_data_i(rx_data), .rx_ready_o(rx_ready), .line_err_i(lerr),
    .modem_change_i(mchg), .sample_tick_i(tick), .tx_serial_o(txs),
    .tx_ready_o(txr), .host_rdata_o(rdata), .host_rdata_oe_o(oe),
    .interrupt_output_o(intr));

  uartdi_far_model uartdi_far_model_i (.mclk_i(mclk), .reset_i(rst),
    .send_i(send), .send_data_i(sdata), .rx_ready_i(rx_ready),
    .tx_serial_i(txs), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
    .sample_tick_o(tick), .got_o(got), .got_data_o(got_data));

  always @(posedge mclk) if (got === 1'b1) got_q.push_back(got_data);

  task automatic chk(input string nm, input logic [7:0] s, e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic rd(input logic [3:0] a);
    @(negedge mclk);
    host.host_address_lines = a;
    host.host_read_strobe   = 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rd_v = rdata;
    oe_v = oe;
    host.host_read_strobe = 1'b0;
    @(negedge mclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk);
    host.host_address_lines = a;
    host.wdata              = d;
    host.host_write_strobe  = 1'b1;
    @(negedge mclk);
    host.host_write_strobe = 1'b0;
    @(negedge mclk);
  endtask

  // Event pulse: 0 line error, 1 modem change, 2 offer a character
  task automatic ev(input int k, input logic [7:0] d);
    @(negedge mclk);
    sdata = d;
    lerr  = (k == 0);
    mchg  = (k == 1);
    send  = (k == 2);
    @(negedge mclk);
    {lerr, mchg, send} = 3'h0;
    repeat (6) @(negedge mclk);
  endtask

  // Strobe held on an unmapped place so the gating can be seen
  task automatic hold_chk(input logic [7:0] e);
    @(negedge mclk);
    host.host_address_lines = 4'h7;
    host.host_read_strobe   = 1'b1;
    repeat (3) @(negedge mclk);
    chk("intr", {7'h00, intr}, e);
    chk("oe", {7'h00, oe}, 8'h00);
    host.host_read_strobe = 1'b0;
    @(negedge mclk);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    // Three frames take about 2000 cycles; ample margin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    rd(ADDR_IEN);
    chk("ien", rd_v, 8'h00);
    rd(ADDR_IID);
    chk("iid", rd_v, 8'h01);
    wr(ADDR_IEN, 8'hFF);
    rd(ADDR_IEN);
    chk("ien", rd_v, 8'h1F);
    wr(ADDR_IEN, 8'h05);
    ev(2, 8'hA5);
    chk("intr", {7'h00, intr}, 8'h01);
    chk("rxready", {7'h00, rx_ready}, 8'h00);
    rd(ADDR_IID);
    chk("iid", rd_v, 8'h04);
    ev(0, 8'h00);
    rd(ADDR_IID);
    chk("iid", rd_v, 8'h04);
    rd(ADDR_DATA);
    chk("rbuf", rd_v, 8'h05);
    chk("rxready", {7'h00, rx_ready}, 8'h01);
    rd(ADDR_IID);
    chk("iid", rd_v, 8'h06);
    rd(ADDR_LSTAT);
    rd(ADDR_IID);
    chk("iid", rd_v, 8'h01);
    chk("intr", {7'h00, intr}, 8'h00);
    wr(ADDR_IEN, 8'h00);
    ev(2, 8'h3C);
    rd(ADDR_IID);
    chk("iid", rd_v, 8'h01);
    chk("intr", {7'h00, intr}, 8'h00);
    wr(ADDR_IEN, 8'h11);
    hold_chk(8'h00);
    wr(ADDR_IEN, 8'h01);
    hold_chk(8'h01);
    fmt.word_len = 2'h3;
    rd(ADDR_DATA);
    chk("rbuf", rd_v, 8'h3C);
    wr(ADDR_IEN, 8'h08);
    ev(1, 8'h00);
    rd(ADDR_IID);
    chk("iid", rd_v, 8'h00);
    rd(ADDR_MSTAT);
    rd(ADDR_IID);
    chk("iid", rd_v, 8'h01);
    pmode = 1'b0;
    rd(4'h9);
    chk("ien", rd_v, 8'h08);
    pmode = 1'b1;
    rd(4'h9);
    chk("oe", {7'h00, oe_v}, 8'h00);
    fmt.divisor_access_select = 1'b1;
    rd(ADDR_IEN);
    chk("oe", {7'h00, oe_v}, 8'h00);
    fmt.divisor_access_select = 1'b0;
    wr(ADDR_IEN, 8'h02);
    wr(ADDR_DATA, 8'h3C);
    wr(ADDR_DATA, 8'h5A);
    wr(ADDR_DATA, 8'h81);
    chk("txready", {7'h00, txr}, 8'h00);
    wr(ADDR_DATA, 8'hFF);
    for (int i = 0; i < 4000 && got_q.size() < 3; i++) @(negedge mclk);
    repeat (800) @(negedge mclk);
    chk("frames", 8'(got_q.size()), 8'h03);
    for (int i = 0; i < 3 && i < got_q.size(); i++)
      chk("frame", got_q[i], i == 0 ? 8'h3C : (i == 1 ? 8'h5A : 8'h81));
    chk("intr", {7'h00, intr}, 8'h01);
    chk("txready", {7'h00, txr}, 8'h01);
    rd(ADDR_IID);
    chk("iid", rd_v, 8'h02);
    rd(ADDR_IID);
    chk("iid", rd_v, 8'h01);
    chk("intr", {7'h00, intr}, 8'h00);
    end_of_test();
  end
endmodule // uartdi_regs_bench

`default_nettype wire
